// File: hw/nvsi_slave.sv
// nvsi_slave: two-wire serial slave with 8k x 8 ram behind it
// assumes scl and sda arrive asynchronous and the pad resolves sda from sda_oe
`timescale 1ns/1ps
`default_nettype none
module nvsi_slave
  import nvsi_pkg::*;
#(
  parameter int ADDR_W = NVSI_ADDR_W,
  parameter int STRAP_W = NVSI_STRAP_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // static pins
  input wire logic write_protect,
  input wire logic [STRAP_W-1:0] slave_address_straps,
  // status
  output logic bus_busy,
  output logic hs_mode,
  output logic selected
);

  // refuse parameter values the address and select logic cannot serve
  if (ADDR_W < 9 || ADDR_W > 16) begin : g_bad_addr_w
    $error("nvsi_slave: ADDR_W must be 9..16");
  end
  if (STRAP_W != 3) begin : g_bad_strap_w
    $error("nvsi_slave: STRAP_W must be 3");
  end

  localparam int DEPTH = 1 << ADDR_W;
  localparam int HI_W = ADDR_W - 8;

  logic [NVSI_DATA_W-1:0] mem [DEPTH];

  // two-stage synchronisers
  logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
  logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
  logic wp_s1_reg, wp_s2_reg;
  logic [STRAP_W-1:0] strap_s1_reg, strap_s2_reg;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
      wp_s1_reg <= 1'b0;
      wp_s2_reg <= 1'b0;
      strap_s1_reg <= '0;
      strap_s2_reg <= '0;
    end else begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
      wp_s1_reg <= write_protect;
      wp_s2_reg <= wp_s1_reg;
      strap_s1_reg <= slave_address_straps;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // bus events
  wire scl_rise = scl_s2_reg && !scl_s3_reg;
  wire scl_fall = !scl_s2_reg && scl_s3_reg;
  wire start_det = scl_s2_reg && scl_s3_reg && !sda_s2_reg && sda_s3_reg;
  wire stop_det = scl_s2_reg && scl_s3_reg && sda_s2_reg && !sda_s3_reg;

  nvsi_state_e state_reg, state_next;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [HI_W-1:0] addr_hi_reg;
  logic [7:0] tx_reg;
  logic ack_drive_reg, nack_pending_reg, master_nack_reg;

  wire in_ack = bit_reg == NVSI_ACK_BIT;
  wire [7:0] shift_in = {shift_reg[6:0], sda_s2_reg};
  wire [7:0] rx_byte = shift_reg;
  wire sel_match = rx_byte[7:4] == NVSI_MEM_PREFIX && rx_byte[3:1] == strap_s2_reg;
  wire hs_code = rx_byte[7:3] == NVSI_HS_CODE_MASK;
  wire [ADDR_W-1:0] addr_inc = addr_reg + 1'b1;
  wire wr_block = wp_s2_reg;
  wire byte_done = scl_fall && bit_reg == NVSI_LAST_BIT;
  wire ack_end = scl_fall && in_ack;

  // next state after a received byte
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      NVSI_IDLE: state_next = NVSI_IDLE;
      NVSI_SEL: begin
        if (!sel_match) state_next = NVSI_IGN;
        else if (rx_byte[0]) state_next = NVSI_RDAT;
        else state_next = NVSI_ADRH;
      end
      NVSI_ADRH: state_next = NVSI_ADRL;
      NVSI_ADRL: state_next = NVSI_WDAT;
      NVSI_WDAT: state_next = NVSI_WDAT;
      NVSI_RDAT: state_next = NVSI_RDAT;
      NVSI_IGN: state_next = NVSI_IGN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_reg <= NVSI_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      addr_reg <= '0;
      addr_hi_reg <= '0;
      tx_reg <= 8'hff;
      ack_drive_reg <= 1'b0;
      nack_pending_reg <= 1'b0;
      master_nack_reg <= 1'b0;
      bus_busy <= 1'b0;
      hs_mode <= 1'b0;
    end else if (start_det) begin
      state_reg <= NVSI_SEL;
      // the scl fall that closes the start wraps this to zero
      bit_reg <= 4'hf;
      ack_drive_reg <= 1'b0;
      master_nack_reg <= 1'b0;
      bus_busy <= 1'b1;
    end else if (stop_det) begin
      state_reg <= NVSI_IDLE;
      bit_reg <= 4'h0;
      ack_drive_reg <= 1'b0;
      bus_busy <= 1'b0;
      hs_mode <= 1'b0;
    end else if (state_reg != NVSI_IDLE && state_reg != NVSI_IGN) begin
      if (scl_rise && !in_ack) begin
        shift_reg <= shift_in;
      end
      if (scl_rise && in_ack && state_reg == NVSI_RDAT) begin
        master_nack_reg <= sda_s2_reg;
      end
      if (byte_done) begin
        bit_reg <= NVSI_ACK_BIT;
        state_reg <= state_next;
        if (state_reg == NVSI_SEL && hs_code) begin
          hs_mode <= 1'b1;
        end
        // acknowledge only what this side received and accepted
        ack_drive_reg <= state_reg != NVSI_RDAT && !(state_reg == NVSI_SEL && !sel_match)
          && !(state_reg == NVSI_WDAT && wr_block);
        if (state_reg == NVSI_ADRH) begin
          addr_hi_reg <= rx_byte[HI_W-1:0];
        end
        if (state_reg == NVSI_ADRL) begin
          addr_reg <= {addr_hi_reg, rx_byte};
        end
        if (state_reg == NVSI_WDAT) begin
          if (!wr_block) begin
            mem[addr_reg] <= rx_byte;
          end
          addr_reg <= addr_inc;
        end
        if (state_reg == NVSI_RDAT) begin
          addr_reg <= addr_inc;
        end
      end else if (ack_end) begin
        bit_reg <= 4'h0;
        ack_drive_reg <= 1'b0;
        if (state_reg == NVSI_RDAT && master_nack_reg) begin
          state_reg <= NVSI_IGN;
        end
      end else if (scl_fall) begin
        bit_reg <= bit_reg + 4'h1;
      end
      if (state_reg == NVSI_SEL && byte_done && sel_match && rx_byte[0]) begin
        tx_reg <= mem[addr_reg];
      end else if (state_reg == NVSI_RDAT && ack_end && !master_nack_reg) begin
        tx_reg <= mem[addr_reg];
      end else if (state_reg == NVSI_RDAT && scl_fall && !in_ack && bit_reg != NVSI_LAST_BIT) begin
        tx_reg <= {tx_reg[6:0], 1'b1};
      end
      nack_pending_reg <= state_reg == NVSI_SEL && byte_done && !sel_match;
    end
  end

  // pad drive: only ever pulls low, changes only after scl falls
  wire drive_low = ack_drive_reg || (state_reg == NVSI_RDAT && !in_ack && !tx_reg[7]);
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      selected <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe <= drive_low && !start_det && !stop_det;
      selected <= state_reg inside {NVSI_ADRH, NVSI_ADRL, NVSI_WDAT, NVSI_RDAT};
    end
  end

  // checks
  property p_busy_start;
    @(posedge ref_clk) disable iff (!nrst) start_det |=> bus_busy;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("bus not busy after start");

  property p_idle_stop;
    @(posedge ref_clk) disable iff (!nrst) stop_det |=> state_reg == NVSI_IDLE && !hs_mode;
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("stop did not end transaction");

  property p_ign_quiet;
    @(posedge ref_clk) disable iff (!nrst) state_reg == NVSI_IGN && !start_det |=> !sda_oe;
  endproperty
  a_ign_quiet: assert property (p_ign_quiet) else $error("driving sda while ignoring");

  property p_sel_ack;
    @(posedge ref_clk) disable iff (!nrst)
      state_reg == NVSI_SEL && byte_done && sel_match && !start_det && !stop_det |=> ##1 sda_oe;
  endproperty
  a_sel_ack: assert property (p_sel_ack) else $error("matching select not acknowledged");

  property p_wp_nack;
    @(posedge ref_clk) disable iff (!nrst)
      state_reg == NVSI_WDAT && byte_done && wr_block && !start_det && !stop_det |=> !ack_drive_reg;
  endproperty
  a_wp_nack: assert property (p_wp_nack) else $error("protected write acknowledged");

  property p_inc;
    @(posedge ref_clk) disable iff (!nrst)
      state_reg inside {NVSI_WDAT, NVSI_RDAT} && byte_done && !start_det && !stop_det
      |=> addr_reg == $past(addr_reg) + 1'b1;
  endproperty
  a_inc: assert property (p_inc) else $error("address did not advance");

  property p_sda_stable;
    @(posedge ref_clk) disable iff (!nrst) scl_s2_reg && scl_s3_reg && !start_det && !stop_det |=> $stable(sda_oe);
  endproperty
  a_sda_stable: assert property (p_sda_stable) else $error("sda moved while scl high");

  property p_nack_release;
    @(posedge ref_clk) disable iff (!nrst)
      state_reg == NVSI_RDAT && ack_end && master_nack_reg && !start_det && !stop_det |=> ##1 !sda_oe;
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("sda held after master nack");

  property p_sel_nack;
    @(posedge ref_clk) disable iff (!nrst) nack_pending_reg |-> !ack_drive_reg;
  endproperty
  a_sel_nack: assert property (p_sel_nack) else $error("refused select acknowledged");

  property p_restart;
    @(posedge ref_clk) disable iff (!nrst) start_det |=> state_reg == NVSI_SEL;
  endproperty
  a_restart: assert property (p_restart) else $error("start did not wait for a select byte");

  property p_free_stop;
    @(posedge ref_clk) disable iff (!nrst) stop_det |=> !bus_busy;
  endproperty
  a_free_stop: assert property (p_free_stop) else $error("bus still busy after stop");

  property p_byte_len;
    @(posedge ref_clk) disable iff (!nrst)
      byte_done && state_reg != NVSI_IDLE && state_reg != NVSI_IGN && !start_det && !stop_det |=> in_ack;
  endproperty
  a_byte_len: assert property (p_byte_len) else $error("acknowledge slot not after eight bits");

  property p_ack_release;
    @(posedge ref_clk) disable iff (!nrst)
      ack_end && state_reg != NVSI_IDLE && state_reg != NVSI_IGN && !start_det && !stop_det |=> !ack_drive_reg;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("acknowledge held past ninth clock");

  property p_wrap;
    @(posedge ref_clk) disable iff (!nrst)
      state_reg inside {NVSI_WDAT, NVSI_RDAT} && byte_done && &addr_reg && !start_det && !stop_det |=> addr_reg == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("address did not wrap to zero");

  property p_addr_load;
    @(posedge ref_clk) disable iff (!nrst)
      state_reg == NVSI_ADRL && byte_done && !start_det && !stop_det |=> addr_reg == {$past(addr_hi_reg), $past(rx_byte)};
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("loaded address wrong");

  property p_wr_land;
    @(posedge ref_clk) disable iff (!nrst)
      state_reg == NVSI_WDAT && byte_done && !wr_block && !start_det && !stop_det |=> mem[$past(addr_reg)] == $past(rx_byte);
  endproperty
  a_wr_land: assert property (p_wr_land) else $error("written byte did not land");

  property p_wp_keep;
    @(posedge ref_clk) disable iff (!nrst)
      state_reg == NVSI_WDAT && byte_done && wr_block && !start_det && !stop_det |=> mem[$past(addr_reg)] == $past(mem[addr_reg]);
  endproperty
  a_wp_keep: assert property (p_wp_keep) else $error("protected location changed");

  property p_rd_load;
    @(posedge ref_clk) disable iff (!nrst)
      state_reg == NVSI_SEL && byte_done && sel_match && rx_byte[0] && !start_det && !stop_det |=> tx_reg == mem[addr_reg];
  endproperty
  a_rd_load: assert property (p_rd_load) else $error("read not from current address");

  property p_hs_enter;
    @(posedge ref_clk) disable iff (!nrst)
      state_reg == NVSI_SEL && byte_done && hs_code && !start_det && !stop_det |=> hs_mode && state_reg == NVSI_IGN;
  endproperty
  a_hs_enter: assert property (p_hs_enter) else $error("master code not taken");

  c_write: cover property (@(posedge ref_clk) disable iff (!nrst) state_reg == NVSI_WDAT && byte_done);
  c_read: cover property (@(posedge ref_clk) disable iff (!nrst) state_reg == NVSI_RDAT && ack_end);
  c_ignore: cover property (@(posedge ref_clk) disable iff (!nrst) state_reg == NVSI_IGN);
  c_hs: cover property (@(posedge ref_clk) disable iff (!nrst) hs_mode);
  c_restart: cover property (@(posedge ref_clk) disable iff (!nrst) start_det && bus_busy);

endmodule // nvsi_slave
`default_nettype wire

// File: inc/nvsi_pkg.sv
// nvsi_pkg: constants for the two-wire serial slave of a byte-wide nonvolatile ram
// assumes nothing beyond a systemverilog compiler
package nvsi_pkg;
  localparam int NVSI_ADDR_W = 13;
  localparam int NVSI_DATA_W = 8;
  localparam int NVSI_STRAP_W = 3;
  localparam logic [3:0] NVSI_MEM_PREFIX = 4'ha;
  localparam logic [12:0] NVSI_ADDR_RST = 13'h0000;
  localparam logic [3:0] NVSI_LAST_BIT = 4'h7;
  localparam logic [3:0] NVSI_ACK_BIT = 4'h8;
  localparam logic [4:0] NVSI_HS_CODE_MASK = 5'h01;
  localparam int NVSI_SCL_PERIOD_NS = 320;
  localparam int NVSI_CLK_PERIOD_NS = 40;
  localparam int NVSI_SCL_CYCLES = NVSI_SCL_PERIOD_NS / NVSI_CLK_PERIOD_NS;
  typedef enum logic [6:0] {
    NVSI_IDLE = 7'h01,
    NVSI_SEL = 7'h02,
    NVSI_ADRH = 7'h04,
    NVSI_ADRL = 7'h08,
    NVSI_WDAT = 7'h10,
    NVSI_RDAT = 7'h20,
    NVSI_IGN = 7'h40
  } nvsi_state_e;
endpackage

// File: sim/nvsi_master_model.sv
// nvsi_master_model: bus master that drives scl and pulls sda low
// assumes the bench resolves sda with a pull-up from every pull-down
`timescale 1ns/1ps
`default_nettype none
module nvsi_master_model (
  // clock
  input wire logic ref_clk,
  // bus
  input wire logic sda_in,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // 5 cycles low, 3 high: 320 ns per bit
  task automatic bit_io(input logic b, output logic r);
    w(1);
    sda_low <= !b;
    w(4);
    scl <= 1'b1;
    w(2);
    r = sda_in;
    w(1);
    scl <= 1'b0;
  endtask
  task automatic start();
    w(1);
    sda_low <= 1'b0;
    w(4);
    scl <= 1'b1;
    w(4);
    sda_low <= 1'b1;
    w(4);
    scl <= 1'b0;
  endtask
  task automatic stop();
    w(1);
    sda_low <= 1'b1;
    w(4);
    scl <= 1'b1;
    w(4);
    sda_low <= 1'b0;
    w(4);
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule // nvsi_master_model
`default_nettype wire

// File: sim/tb_nvsi_slave.sv
// tb_nvsi_slave: self-checking bench for the serial slave
// assumes nvsi_master_model as bus master and a pull-up on sda
`timescale 1ns/1ps
`default_nettype none
module tb_nvsi_slave;
  import nvsi_pkg::*;
  localparam logic [7:0] SW = {NVSI_MEM_PREFIX, 3'h5, 1'b0};
  localparam logic [7:0] SR = {NVSI_MEM_PREFIX, 3'h5, 1'b1};
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic write_protect = 1'b0;
  logic [2:0] straps = 3'h5;
  logic sda_out, sda_oe, bus_busy, hs_mode, selected, scl, m_low, a;
  logic [7:0] d;
  logic [7:0] bad [3] = '{8'ha8, 8'h3a, 8'hf0};
  int n_errors = 0;
  int n_compared = 0;
  wire logic sda = !(m_low || (sda_oe && !sda_out));
  nvsi_slave u_dut (.ref_clk(ref_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .write_protect(write_protect), .slave_address_straps(straps),
    .bus_busy(bus_busy), .hs_mode(hs_mode), .selected(selected));
  nvsi_master_model u_mst (.ref_clk(ref_clk), .sda_in(sda), .scl(scl), .sda_low(m_low));
  always #20 ref_clk = !ref_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic done(input string s);
    $display("%s finished, errors so far %0d", s, n_errors);
  endtask
  task automatic addr_wr(input logic [12:0] ad);
    u_mst.start();
    u_mst.wr(SW, a);
    chk(a, 1'b1);
    u_mst.wr({3'h7, ad[12:8]}, a);
    chk(a, 1'b1);
    u_mst.wr(ad[7:0], a);
    chk(a, 1'b1);
  endtask
  task automatic t_burst();
    addr_wr(13'h1fff);
    chk({bus_busy, selected}, 2'h3);
    for (int i = 1; i <= 3; i++) begin
      u_mst.wr(8'h11 * i, a);
      chk(a, 1'b1);
    end
    u_mst.stop();
    u_mst.w(4);
    chk({bus_busy, selected}, 2'h0);
    done("burst");
  endtask
  task automatic t_read();
    addr_wr(13'h1fff);
    u_mst.start();
    u_mst.wr(SR, a);
    chk(a, 1'b1);
    u_mst.rd(1'b0, d);
    chk(d, 8'h11);
    u_mst.rd(1'b1, d);
    chk(d, 8'h22);
    u_mst.w(4);
    chk(sda_oe, 1'b0);
    u_mst.stop();
    u_mst.start();
    u_mst.wr(SR, a);
    u_mst.rd(1'b1, d);
    chk(d, 8'h33);
    u_mst.stop();
    done("read");
  endtask
  task automatic t_ignore();
    foreach (bad[i]) begin
      u_mst.start();
      u_mst.wr(bad[i], a);
      chk(a, 1'b0);
      u_mst.wr(8'h00, a);
      chk({a, selected}, 2'h0);
      u_mst.stop();
    end
    straps <= 3'h2;
    u_mst.w(4);
    u_mst.start();
    u_mst.wr({NVSI_MEM_PREFIX, 3'h2, 1'b0}, a);
    chk(a, 1'b1);
    u_mst.stop();
    straps <= 3'h5;
    u_mst.w(4);
    done("ignore");
  endtask
  task automatic t_wp();
    addr_wr(13'h0010);
    u_mst.wr(8'haa, a);
    u_mst.stop();
    write_protect <= 1'b1;
    addr_wr(13'h0010);
    u_mst.wr(8'h55, a);
    chk(a, 1'b0);
    u_mst.stop();
    write_protect <= 1'b0;
    addr_wr(13'h0010);
    u_mst.stop();
    u_mst.start();
    u_mst.wr(SR, a);
    u_mst.rd(1'b1, d);
    chk(d, 8'haa);
    u_mst.stop();
    done("protect");
  endtask
  task automatic t_hs();
    u_mst.start();
    u_mst.wr(8'h08, a);
    chk({a, hs_mode}, 2'h1);
    u_mst.stop();
    u_mst.w(4);
    chk(hs_mode, 1'b0);
    done("high speed");
  endtask
  task automatic test_done();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({bus_busy, hs_mode, selected, sda_oe}, 4'h0);
    t_burst();
    t_read();
    t_ignore();
    t_wp();
    t_hs();
    test_done();
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    test_done();
  end
endmodule // tb_nvsi_slave
`default_nettype wire
